// File: hdl/pid_pkg.sv
package pid_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DW      = 16;
    localparam int IW      = 24;
    localparam int NSETS   = 8;
    localparam int SET_W   = 3;
    localparam int FLD_W   = 4;
    localparam int PCT_W   = 7;
    localparam int FRAC    = 8;

    // ----------------------------------------------------------------
    // algorithm and option codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_PD    = 2'h0;
    localparam logic [1:0] MODE_PI    = 2'h1;
    localparam logic [1:0] MODE_PID   = 2'h2;
    localparam logic       DSRC_MEAS  = 1'h0;
    localparam logic       DSRC_DEV   = 1'h1;
    localparam logic       INIT_NONE  = 1'h0;
    localparam logic       INIT_VALUE = 1'h1;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

    // ----------------------------------------------------------------
    // configuration field selectors
    // ----------------------------------------------------------------
    localparam logic [FLD_W-1:0] FLD_MODE = 4'h0;
    localparam logic [FLD_W-1:0] FLD_DSRC = 4'h1;
    localparam logic [FLD_W-1:0] FLD_INIT = 4'h2;
    localparam logic [FLD_W-1:0] FLD_KP   = 4'h3;
    localparam logic [FLD_W-1:0] FLD_KI   = 4'h4;
    localparam logic [FLD_W-1:0] FLD_KD   = 4'h5;
    localparam logic [FLD_W-1:0] FLD_DZ   = 4'h6;
    localparam logic [FLD_W-1:0] FLD_OFFS = 4'h7;
    localparam logic [FLD_W-1:0] FLD_LO   = 4'h8;
    localparam logic [FLD_W-1:0] FLD_HI   = 4'h9;
    localparam logic [FLD_W-1:0] FLD_PCT  = 4'hA;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]        RST_MODE = MODE_PID;
    localparam logic signed [15:0] RST_KP  = 16'sh0100;
    localparam logic signed [15:0] RST_LO  = 16'sh8000;
    localparam logic signed [15:0] RST_HI  = 16'sh7FFF;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PID_ST_IDLE = 2'b01,
        PID_ST_RUN  = 2'b10
    } pid_state_t;

    typedef struct packed {
        logic [1:0]        mode;
        logic              dsrc;
        logic              init_val;
        logic signed [15:0] kp;
        logic signed [15:0] ki;
        logic signed [15:0] kd;
        logic signed [15:0] dz;
        logic signed [15:0] offs;
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic [PCT_W-1:0]  pct;
    } pid_set_t;

    typedef struct packed {
        pid_set_t [NSETS-1:0] sets;
        pid_state_t           state;
        logic [SET_W-1:0]     sel;
        logic signed [IW-1:0] integ;
        logic signed [IW-1:0] prev_d;
        logic signed [DW-1:0] act;
        logic                 act_vld;
    } pid_regs_t;

    // ----------------------------------------------------------------
    // saturation helpers
    // ----------------------------------------------------------------
    function automatic logic signed [IW-1:0] pid_sat24(input logic signed [31:0] v);
        logic signed [IW-1:0] res;
        res = v[IW-1:0];
        if (v > 32'sh007FFFFF) begin
            res = 24'sh7FFFFF;
        end else if (v < -32'sh00800000) begin
            res = -24'sh800000;
        end
        return res;
    endfunction

endpackage

// File: hdl/pid_mul.sv
`timescale 1ns/1ps
// signed value times q8.8 coefficient, saturated
module pid_mul (
    input  wire logic signed [23:0] val_in,
    input  wire logic signed [15:0] coef_in,
    output logic signed [23:0]      prod_out
);
    logic signed [39:0] full;
    logic signed [31:0] shifted;

    always_comb begin
        full     = val_in * coef_in;
        shifted  = full[39:8];
        prod_out = pid_pkg::pid_sat24(shifted);
    end
endmodule

// File: hdl/pid_control_loop.sv
`timescale 1ns/1ps
// What this block does
// - eight independent parameter sets; the starting channel picks one.
// - error is setpoint minus feedback; output acts to shrink it.
// - each set selects PD, PI or PID algorithm.
// - while running, a sample changes the output only when error magnitude exceeds the dead zone.
// - proportional coefficient scales the result in every mode.
// - integral term used in PI and PID only, excluded in PD.
// - derivative term and source used in PD and PID only.
// - measured source feeds negated feedback into the derivative term.
// - deviation source feeds the dead-zone-checked error into the derivative term.
// - programmable offset added to the computed output.
// - after offset the output is clamped to low and high limits.
// - no-init start gives zero output and zero internal state.
// - value start gives low plus percentage of span, 0 to 100.
// - out = P*(x + Ki*(x + s_prev) + D*(d - d_prev)).
module pid_control_loop (
    input  wire logic                    core_clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    cfg_we_in,
    input  wire logic [2:0]              cfg_set_in,
    input  wire logic [3:0]              cfg_field_in,
    input  wire logic [15:0]             cfg_data_in,
    input  wire logic                    start_in,
    input  wire logic                    stop_in,
    input  wire logic [2:0]              set_sel_in,
    input  wire logic                    sample_in,
    input  wire logic signed [15:0]      setpoint_in,
    input  wire logic signed [15:0]      feedback_in,
    output logic signed [15:0]           act_out,
    output logic                         act_valid_out,
    output logic                         running_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pid_pkg::pid_regs_t   r;
    pid_pkg::pid_regs_t   n;
    pid_pkg::pid_set_t    cur;
    logic signed [31:0]   err32;
    logic signed [23:0]   x;
    logic signed [31:0]   abs_x;
    logic                 outside;
    logic                 use_i;
    logic                 use_d;
    logic                 eval;
    logic signed [23:0]   d_in;
    logic signed [23:0]   s_sum;
    logic signed [23:0]   d_diff;
    logic signed [23:0]   iterm_raw;
    logic signed [23:0]   dterm_raw;
    logic signed [23:0]   tot;
    logic signed [23:0]   pterm;
    logic signed [31:0]   out32;
    logic signed [15:0]   clamped;
    logic signed [31:0]   span;
    logic signed [39:0]   span_pct;
    logic signed [31:0]   init32;
    logic [6:0]           pct_lim;

    // ----------------------------------------------------------------
    // multipliers
    // ----------------------------------------------------------------
    pid_mul u_mul_i (
        .val_in   (s_sum),
        .coef_in  (cur.ki),
        .prod_out (iterm_raw)
    );

    pid_mul u_mul_d (
        .val_in   (d_diff),
        .coef_in  (cur.kd),
        .prod_out (dterm_raw)
    );

    pid_mul u_mul_p (
        .val_in   (tot),
        .coef_in  (cur.kp),
        .prod_out (pterm)
    );

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    always_comb begin
        cur     = r.sets[r.sel];
        err32   = 32'(setpoint_in) - 32'(feedback_in);
        x       = pid_pkg::pid_sat24(err32);
        abs_x   = (err32 < 0) ? -err32 : err32;
        outside = abs_x > ((cur.dz < 0) ? -32'(cur.dz) : 32'(cur.dz));
        use_i   = (cur.mode == pid_pkg::MODE_PI) || (cur.mode == pid_pkg::MODE_PID);
        use_d   = (cur.mode == pid_pkg::MODE_PD) || (cur.mode == pid_pkg::MODE_PID);
        d_in    = (cur.dsrc == pid_pkg::DSRC_MEAS) ? -24'(feedback_in) : x;
        s_sum   = pid_pkg::pid_sat24(32'(r.integ) + 32'(x));
        d_diff  = pid_pkg::pid_sat24(32'(d_in) - 32'(r.prev_d));
        tot     = pid_pkg::pid_sat24(32'(x)
                  + (use_i ? 32'(iterm_raw) : 32'sh0)
                  + (use_d ? 32'(dterm_raw) : 32'sh0));
        out32   = 32'(pterm) + 32'(cur.offs);
        if (out32 < 32'(cur.lo)) begin
            clamped = cur.lo;
        end else if (out32 > 32'(cur.hi)) begin
            clamped = cur.hi;
        end else begin
            clamped = out32[15:0];
        end
        eval = sample_in && (r.state == pid_pkg::PID_ST_RUN) && !start_in;
    end

    // ----------------------------------------------------------------
    // start value from the selected set
    // ----------------------------------------------------------------
    pid_pkg::pid_set_t ss;

    always_comb begin
        ss       = r.sets[set_sel_in];
        pct_lim  = (ss.pct > pid_pkg::PCT_FULL) ? pid_pkg::PCT_FULL : ss.pct;
        span     = 32'(ss.hi) - 32'(ss.lo);
        span_pct = 40'(span) * 40'(pct_lim);
        init32   = 32'(ss.lo) + 32'(span_pct / 40'sh64);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = r;
        n.act_vld = 1'b0;
        if (cfg_we_in) begin
            if (cfg_field_in == pid_pkg::FLD_MODE) begin
                n.sets[cfg_set_in].mode = cfg_data_in[1:0];
            end else if (cfg_field_in == pid_pkg::FLD_DSRC) begin
                n.sets[cfg_set_in].dsrc = cfg_data_in[0];
            end else if (cfg_field_in == pid_pkg::FLD_INIT) begin
                n.sets[cfg_set_in].init_val = cfg_data_in[0];
            end else if (cfg_field_in == pid_pkg::FLD_KP) begin
                n.sets[cfg_set_in].kp = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_KI) begin
                n.sets[cfg_set_in].ki = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_KD) begin
                n.sets[cfg_set_in].kd = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_DZ) begin
                n.sets[cfg_set_in].dz = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_OFFS) begin
                n.sets[cfg_set_in].offs = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_LO) begin
                n.sets[cfg_set_in].lo = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_HI) begin
                n.sets[cfg_set_in].hi = cfg_data_in;
            end else if (cfg_field_in == pid_pkg::FLD_PCT) begin
                n.sets[cfg_set_in].pct = cfg_data_in[6:0];
            end
        end
        case (r.state)
            pid_pkg::PID_ST_IDLE: begin
                n.act = 16'sh0000;
            end
            pid_pkg::PID_ST_RUN: begin
                if (stop_in) begin
                    n.state = pid_pkg::PID_ST_IDLE;
                end else if (eval && outside) begin
                    n.act = clamped;
                    if (use_i) begin
                        n.integ = s_sum;
                    end
                    if (use_d) begin
                        n.prev_d = d_in;
                    end
                end
                n.act_vld = eval;
            end
            default: begin
                n.state = pid_pkg::PID_ST_IDLE;
            end
        endcase
        if (start_in) begin
            n.state   = pid_pkg::PID_ST_RUN;
            n.sel     = set_sel_in;
            n.integ   = 24'sh000000;
            n.prev_d  = 24'sh000000;
            n.act_vld = 1'b0;
            if (ss.init_val == pid_pkg::INIT_VALUE) begin
                n.act = init32[15:0];
            end else begin
                n.act = 16'sh0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < pid_pkg::NSETS; i++) begin
                r.sets[i].mode     <= pid_pkg::RST_MODE;
                r.sets[i].dsrc     <= pid_pkg::DSRC_MEAS;
                r.sets[i].init_val <= pid_pkg::INIT_NONE;
                r.sets[i].kp       <= pid_pkg::RST_KP;
                r.sets[i].ki       <= 16'sh0000;
                r.sets[i].kd       <= 16'sh0000;
                r.sets[i].dz       <= 16'sh0000;
                r.sets[i].offs     <= 16'sh0000;
                r.sets[i].lo       <= pid_pkg::RST_LO;
                r.sets[i].hi       <= pid_pkg::RST_HI;
                r.sets[i].pct      <= 7'h00;
            end
            r.state   <= pid_pkg::PID_ST_IDLE;
            r.sel     <= 3'h0;
            r.integ   <= 24'sh000000;
            r.prev_d  <= 24'sh000000;
            r.act     <= 16'sh0000;
            r.act_vld <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign act_out       = r.act;
    assign act_valid_out = r.act_vld;
    assign running_out   = (r.state == pid_pkg::PID_ST_RUN);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_set_kp_store: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        cfg_we_in && cfg_field_in == pid_pkg::FLD_KP |=> r.sets[$past(cfg_set_in)].kp == $past(cfg_data_in))
        else $error("parameter set write lost");

    a_dead_zone_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && !outside && !stop_in |=> act_out == $past(act_out) && r.integ == $past(r.integ))
        else $error("output moved inside dead zone");

    a_pd_no_integ: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && cur.mode == pid_pkg::MODE_PD |=> r.integ == $past(r.integ))
        else $error("integrator moved in pd mode");

    a_pi_no_deriv: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && cur.mode == pid_pkg::MODE_PI |=> r.prev_d == $past(r.prev_d))
        else $error("derivative state moved in pi mode");

    a_meas_source: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && outside && !stop_in && use_d && cur.dsrc == pid_pkg::DSRC_MEAS
        |=> r.prev_d == -24'($past(feedback_in)))
        else $error("measured source not stored");

    a_dev_source: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && outside && !stop_in && use_d && cur.dsrc == pid_pkg::DSRC_DEV
        |=> r.prev_d == 24'($past(setpoint_in)) - 24'($past(feedback_in)))
        else $error("deviation source not stored");

    a_out_clamped: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && outside && !stop_in && cur.lo <= cur.hi
        |=> act_out >= $past(cur.lo) && act_out <= $past(cur.hi))
        else $error("output outside limits");

    a_init_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        start_in && ss.init_val == pid_pkg::INIT_NONE |=> act_out == 16'sh0000 && r.integ == 24'sh000000)
        else $error("no-init start not zero");

    a_init_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        start_in && ss.init_val == pid_pkg::INIT_VALUE && ss.pct == 7'h00 |=> act_out == $past(ss.lo))
        else $error("0 percent start not low limit");

    a_one_eval: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval |=> act_valid_out ##1 !act_valid_out || $past(eval))
        else $error("sample not answered once");

    a_unity_gain: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && outside && !stop_in && cur.kp == pid_pkg::RST_KP && cur.ki == 16'sh0000 && cur.kd == 16'sh0000
        && cur.offs == 16'sh0000 && cur.lo == pid_pkg::RST_LO && cur.hi == pid_pkg::RST_HI && abs_x < 32'sh8000
        |=> act_out == $past(setpoint_in - feedback_in))
        else $error("unity gain output is not the error");

    a_offset_only: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        eval && outside && !stop_in && cur.kp == 16'sh0000 && cur.offs >= cur.lo && cur.offs <= cur.hi
        |=> act_out == $past(cur.offs))
        else $error("offset not passed to output");

    a_idle_act_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        r.state == pid_pkg::PID_ST_IDLE && !start_in |=> act_out == 16'sh0000)
        else $error("output not zero while idle");

    a_start_clears: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        start_in |=> r.integ == 24'sh000000 && r.prev_d == 24'sh000000)
        else $error("internal state not cleared at start");

    a_start_running: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        start_in |=> running_out && r.sel == $past(set_sel_in))
        else $error("start did not take the chosen set");

    a_init_full: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        start_in && ss.init_val == pid_pkg::INIT_VALUE && ss.pct >= pid_pkg::PCT_FULL |=> act_out == $past(ss.hi))
        else $error("full percent start not high limit");

    a_stop_idles: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        running_out && stop_in && !start_in |=> !running_out)
        else $error("stop did not end running");

    a_valid_pulse: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !eval |=> !act_valid_out)
        else $error("valid without an evaluated sample");

endmodule

// File: dv/pid_tb_plant.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// process side: holds setpoint and feedback, counts act_valid pulses (one per evaluated sample, dead zone included)
// ----------------------------------------------------------------
module pid_tb_plant (
    input  wire logic          clk_in,
    input  wire logic          nrst_in,
    input  wire logic          act_valid_in,
    output logic signed [15:0] setpoint_out,
    output logic signed [15:0] feedback_out,
    output int                 n_valid_out
);
    initial begin
        setpoint_out = 16'h0000;
        feedback_out = 16'h0000;
    end
    // called just after a rising edge, values held until the next call
    task automatic drive(input logic signed [15:0] sp, input logic signed [15:0] fb);
        setpoint_out <= sp;
        feedback_out <= fb;
    endtask
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            n_valid_out <= 0;
        end else if (act_valid_in) begin
            n_valid_out <= n_valid_out + 1;
        end
    end
endmodule

// File: dv/pid_control_loop_tb_top.sv
`timescale 1ns/1ps
module pid_control_loop_tb_top;
    logic               core_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               cfg_we = 1'b0;
    logic [2:0]         cfg_set = 3'h0;
    logic [3:0]         cfg_field = 4'h0;
    logic [15:0]        cfg_data = 16'h0000;
    logic               start = 1'b0;
    logic               stop = 1'b0;
    logic [2:0]         set_sel = 3'h0;
    logic               sample = 1'b0;
    logic signed [15:0] setpoint;
    logic signed [15:0] feedback;
    logic signed [15:0] act;
    logic               act_valid;
    logic               running;
    int                 n_valid;
    int                 n_mismatch = 0;
    int                 check_count = 0;
    int                 n_steps = 0;
    int                 p [8][11];
    int                 cur [11];
    int                 m_integ;
    int                 m_prev;
    int                 m_act;

    always #20 core_clk = ~core_clk;

    pid_control_loop pid_control_loop_i (.core_clk_in(core_clk), .nrst_in(nrst), .cfg_we_in(cfg_we),
        .cfg_set_in(cfg_set), .cfg_field_in(cfg_field), .cfg_data_in(cfg_data), .start_in(start),
        .stop_in(stop), .set_sel_in(set_sel), .sample_in(sample), .setpoint_in(setpoint),
        .feedback_in(feedback), .act_out(act), .act_valid_out(act_valid), .running_out(running));

    pid_tb_plant pid_tb_plant_i (.clk_in(core_clk), .nrst_in(nrst), .act_valid_in(act_valid),
        .setpoint_out(setpoint), .feedback_out(feedback), .n_valid_out(n_valid));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input logic [2:0] s, input logic [3:0] f, input logic [15:0] d);
        @(posedge core_clk);
        cfg_we <= 1'b1;
        cfg_set <= s;
        cfg_field <= f;
        cfg_data <= d;
        @(posedge core_clk);
        cfg_we <= 1'b0;
        p[s][f] = int'($signed(d));
    endtask

    task automatic start_set(input logic [2:0] s);
        int pct;
        @(posedge core_clk);
        start <= 1'b1;
        set_sel <= s;
        @(posedge core_clk);
        start <= 1'b0;
        cur = p[s];
        m_integ = 0;
        m_prev = 0;
        pct = (cur[pid_pkg::FLD_PCT] > 100) ? 100 : cur[pid_pkg::FLD_PCT];
        m_act = 0;
        if (cur[pid_pkg::FLD_INIT] == 1) begin
            m_act = cur[pid_pkg::FLD_LO] + (cur[pid_pkg::FLD_HI] - cur[pid_pkg::FLD_LO]) * pct / 100;
        end
        #1;
        check(act, 16'(m_act));
        check({15'h0000, running}, 16'h0001);
    endtask

    task automatic step(input int sp, input int fb);
        int  x, s, d, it, dt, o;
        bit  ui, ud;
        @(posedge core_clk);
        sample <= 1'b1;
        pid_tb_plant_i.drive(16'(sp), 16'(fb));
        @(posedge core_clk);
        sample <= 1'b0;
        n_steps++;
        x = sp - fb;
        ui = (cur[pid_pkg::FLD_MODE] == pid_pkg::MODE_PI) || (cur[pid_pkg::FLD_MODE] == pid_pkg::MODE_PID);
        ud = (cur[pid_pkg::FLD_MODE] == pid_pkg::MODE_PD) || (cur[pid_pkg::FLD_MODE] == pid_pkg::MODE_PID);
        if ((x < 0 ? -x : x) > (cur[pid_pkg::FLD_DZ] < 0 ? -cur[pid_pkg::FLD_DZ] : cur[pid_pkg::FLD_DZ])) begin
            s = m_integ + x;
            it = ui ? (s * cur[pid_pkg::FLD_KI]) >>> 8 : 0;
            d = (cur[pid_pkg::FLD_DSRC] == pid_pkg::DSRC_MEAS) ? -fb : x;
            dt = ud ? ((d - m_prev) * cur[pid_pkg::FLD_KD]) >>> 8 : 0;
            o = (((x + it + dt) * cur[pid_pkg::FLD_KP]) >>> 8) + cur[pid_pkg::FLD_OFFS];
            o = (o < cur[pid_pkg::FLD_LO]) ? cur[pid_pkg::FLD_LO] : (o > cur[pid_pkg::FLD_HI]) ? cur[pid_pkg::FLD_HI] : o;
            m_integ = ui ? s : m_integ;
            m_prev = ud ? d : m_prev;
            m_act = o;
        end
        #1;
        check({15'h0000, act_valid}, 16'h0001);
        check(act, 16'(m_act));
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic scen_basic();
        start_set(3'h0);
        step(100, 40);
        step(40, 100);
    endtask

    task automatic scen_deadzone();
        cfg(3'h1, pid_pkg::FLD_DZ, 16'h0064);
        start_set(3'h1);
        step(50, 0);
        step(100, 0);
        step(0, 101);
    endtask

    task automatic scen_modes();
        logic [1:0] modes [3] = '{pid_pkg::MODE_PD, pid_pkg::MODE_PI, pid_pkg::MODE_PID};
        cfg(3'h2, pid_pkg::FLD_KP, 16'h0200);
        cfg(3'h2, pid_pkg::FLD_KI, 16'h0100);
        cfg(3'h2, pid_pkg::FLD_KD, 16'h0200);
        for (int m = 0; m < 3; m++) begin
            for (int ds = 0; ds < 2; ds++) begin
                cfg(3'h2, pid_pkg::FLD_MODE, {14'h0000, modes[m]});
                cfg(3'h2, pid_pkg::FLD_DSRC, 16'(ds));
                start_set(3'h2);
                step(30, 10);
                step(50, -20);
                step(5, 25);
            end
        end
    endtask

    task automatic scen_output();
        logic [15:0] pcts [4] = '{16'h0000, 16'h0032, 16'h0064, 16'h0078};
        logic [15:0] offs [3] = '{16'h03E8, 16'h0032, 16'hFC18};
        cfg(3'h3, pid_pkg::FLD_LO, 16'h0000);
        cfg(3'h3, pid_pkg::FLD_HI, 16'h01F4);
        cfg(3'h3, pid_pkg::FLD_INIT, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            cfg(3'h3, pid_pkg::FLD_PCT, pcts[i]);
            start_set(3'h3);
        end
        for (int i = 0; i < 3; i++) begin
            cfg(3'h3, pid_pkg::FLD_OFFS, offs[i]);
            start_set(3'h3);
            step(100, 0);
        end
        cfg(3'h3, pid_pkg::FLD_KP, 16'h0000);
        cfg(3'h3, pid_pkg::FLD_OFFS, 16'h0032);
        start_set(3'h3);
        step(100, 0);
    endtask

    task automatic scen_idle();
        int nv;
        @(posedge core_clk);
        stop <= 1'b1;
        @(posedge core_clk);
        stop <= 1'b0;
        #1;
        check({15'h0000, running}, 16'h0000);
        nv = n_valid;
        check(16'(nv), 16'(n_steps));
        @(posedge core_clk);
        sample <= 1'b1;
        @(posedge core_clk);
        sample <= 1'b0;
        #1;
        check({15'h0000, act_valid}, 16'h0000);
        check(act, 16'h0000);
        @(posedge core_clk);
        #1;
        check(16'(n_valid), 16'(nv));
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        foreach (p[i]) begin
            p[i] = '{default: 0};
            p[i][pid_pkg::FLD_MODE] = pid_pkg::MODE_PID;
            p[i][pid_pkg::FLD_KP] = 256;
            p[i][pid_pkg::FLD_LO] = -32768;
            p[i][pid_pkg::FLD_HI] = 32767;
        end
        repeat (6) @(posedge core_clk);
        #1;
        check(act, 16'h0000);
        check({14'h0000, act_valid, running}, 16'h0000);
        nrst <= 1'b1;
        scen_basic();
        scen_deadzone();
        scen_modes();
        scen_output();
        scen_idle();
        final_report();
    end

    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end
endmodule
